// >>> src/flash_lock_map.svh
// constants for the flash block lock sequencer: commands, bit positions, block map, timing
`ifndef FLASH_LOCK_MAP_SVH
`define FLASH_LOCK_MAP_SVH

// ==========================================================
// command words written to any flash address
`define CMD_READ_ARRAY     16'hffff
`define CMD_PAGE_PROG      16'h4141
`define CMD_LOCK_PROG      16'h7777
`define CMD_BLOCK_ERASE    16'h2020
`define CMD_ERASE_UNLOCKED 16'ha7a7
`define CMD_READ_STATUS    16'h7070
`define CMD_CLEAR_STATUS   16'h5050
`define CMD_READ_LOCK      16'h7171
`define CMD_VERIFY         16'hd0d0

// ==========================================================
// geometry
`define NUM_BLOCKS 11
`define ADDR_W     20
`define DATA_W     16
`define BLK_IDX_W  4

// last even address of each block
`define BLOCK_END_0  20'h03ffe
`define BLOCK_END_1  20'h05ffe
`define BLOCK_END_2  20'h07ffe
`define BLOCK_END_3  20'h0fffe
`define BLOCK_END_4  20'h1fffe
`define BLOCK_END_5  20'h2fffe
`define BLOCK_END_6  20'h3fffe
`define BLOCK_END_7  20'h4fffe
`define BLOCK_END_8  20'h5fffe
`define BLOCK_END_9  20'h6fffe
`define BLOCK_END_10 20'h7fffe

// ==========================================================
// field positions
`define LOCK_PRIMARY_BIT 1
`define LOCK_MIRROR_BIT  9
`define STAT_READY_BIT     7
`define STAT_ERASE_ERR_BIT 5
`define STAT_PROG_ERR_BIT  4

// ==========================================================
// timing
`define CLK_HZ          25000000
`define PAGE_PROG_MS    8
`define BLOCK_ERASE_MS  50
`define PAGE_PROG_CYC   (`PAGE_PROG_MS * (`CLK_HZ / 1000))
`define BLOCK_ERASE_CYC (`BLOCK_ERASE_MS * (`CLK_HZ / 1000))
`define TIMER_W         21

`endif

// >>> src/flash_lock_pkg.sv
// types shared by the flash block lock sequencer
package flash_lock_pkg;
  `include "flash_lock_map.svh"

  // ==========================================================
  // sequencer states
  typedef enum logic [2:0] {
    ST_ARRAY,
    ST_STATUS,
    ST_LOCK_READ,
    ST_PAGE_DATA,
    ST_CONFIRM,
    ST_BUSY
  } seq_state_t;

  // operation waiting for confirm or running
  typedef enum logic [2:0] {
    OP_NONE,
    OP_LOCK,
    OP_ERASE,
    OP_ERASE_ALL,
    OP_PROG
  } pend_op_t;

  typedef logic [`NUM_BLOCKS-1:0] block_mask_t;
  typedef logic [`BLK_IDX_W-1:0]  block_idx_t;
endpackage

// >>> src/flash_lock_seq.sv
// flash command sequencer with per-block lock bits and lock status readout
// ==========================================================
// How it works
// - lock status word read-only, set by reads
// - one lock bit per block, addressed
// - bit 1 lock flag, bit 9 copy
// - other status bits meaningless, read zero
// - lock program command clears block lock bit
// - override then erase sets lock bit
// - only erase can set a lock bit
// - lock bits survive reset and power loss
// - completion shown by ready, times nominal
// - lock read command, then read block end
// - locked block refuses program and erase unless override is high
`timescale 1ns/100ps
module flash_lock_seq import flash_lock_pkg::*; #(
  parameter int PAGE_PROG_CYCLES   = `PAGE_PROG_CYC,
  parameter int BLOCK_ERASE_CYCLES = `BLOCK_ERASE_CYC
) (
  // clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 rst_n,
  // cpu write
  input  wire logic                 wr_en,
  input  wire logic [`ADDR_W-1:0]   wr_addr,
  input  wire logic [`DATA_W-1:0]   wr_data,
  // cpu read
  input  wire logic                 rd_en,
  input  wire logic [`ADDR_W-1:0]   rd_addr,
  output logic      [`DATA_W-1:0]   rd_data_r,
  output logic                      rd_valid_r,
  // array and control
  input  wire logic [`DATA_W-1:0]   array_rdata,
  input  wire logic                 protection_override,
  // status
  output logic                      flash_ready_r
);

  // ==========================================================
  // block map
  localparam logic [`ADDR_W-1:0] BLOCK_END [`NUM_BLOCKS] = '{
    `BLOCK_END_0, `BLOCK_END_1, `BLOCK_END_2, `BLOCK_END_3, `BLOCK_END_4, `BLOCK_END_5,
    `BLOCK_END_6, `BLOCK_END_7, `BLOCK_END_8, `BLOCK_END_9, `BLOCK_END_10};

  // index of the block holding an address
  function automatic block_idx_t block_of(input logic [`ADDR_W-1:0] a);
    block_of = '0;
    for (int i = `NUM_BLOCKS - 1; i >= 0; i--) begin
      if (a <= BLOCK_END[i]) begin
        block_of = block_idx_t'(i);
      end
    end
  endfunction
  // true only at the last even address of a block
  function automatic logic is_block_end(input logic [`ADDR_W-1:0] a);
    is_block_end = 1'b0;
    for (int i = 0; i < `NUM_BLOCKS; i++) begin
      if (a == BLOCK_END[i]) begin
        is_block_end = 1'b1;
      end
    end
  endfunction
  // lock word: flag on bit 1 and bit 9, the rest zero
  function automatic logic [`DATA_W-1:0] lock_word(input logic flag);
    lock_word = '0;
    lock_word[`LOCK_PRIMARY_BIT] = flag;
    lock_word[`LOCK_MIRROR_BIT]  = flag;
  endfunction

  // ==========================================================
  // state
  seq_state_t                state_r, state_nxt;
  pend_op_t                  op_r, op_nxt;
  block_idx_t                tgt_r, tgt_nxt;
  logic [`TIMER_W-1:0]       timer_r, timer_nxt;
  logic                      err_prog_r, err_prog_nxt;
  logic                      err_erase_r, err_erase_nxt;
  logic [`DATA_W-1:0]        rd_data_nxt;
  logic                      rd_valid_nxt;
  logic                      flash_ready_nxt;
  logic [`DATA_W-1:0]        block_lock_status_r, block_lock_status_nxt;
  block_mask_t               set_mask, clr_mask, lock_bits;
  logic [`DATA_W-1:0]        status_word;
  block_idx_t                wr_blk, rd_blk;
  logic                      wr_end, rd_end, err_any, wr_allowed, done;

  lock_bit_store u_store (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .set_mask  (set_mask),
    .clr_mask  (clr_mask),
    .lock_bits (lock_bits)
  );

  // address decode shared by both paths
  always_comb begin
    wr_blk     = block_of(wr_addr);
    wr_end     = is_block_end(wr_addr);
    rd_blk     = block_of(rd_addr);
    rd_end     = is_block_end(rd_addr);
    err_any    = err_prog_r | err_erase_r;
    // a clear override takes effect on the very next operation
    wr_allowed = lock_bits[wr_blk] | protection_override;
    done       = (state_r == ST_BUSY) && (timer_r == `TIMER_W'(1));
    status_word = '0;
    status_word[`STAT_READY_BIT]     = (state_r != ST_BUSY);
    status_word[`STAT_ERASE_ERR_BIT] = err_erase_r;
    status_word[`STAT_PROG_ERR_BIT]  = err_prog_r;
  end

  // ==========================================================
  // command sequencer
  always_comb begin
    state_nxt     = state_r;
    op_nxt        = op_r;
    tgt_nxt       = tgt_r;
    timer_nxt     = timer_r;
    err_prog_nxt  = err_prog_r;
    err_erase_nxt = err_erase_r;
    set_mask      = '0;
    clr_mask      = '0;
    if (state_r == ST_BUSY) begin
      // writes are ignored while the array works
      timer_nxt = timer_r - `TIMER_W'(1);
      if (done) begin
        state_nxt = ST_STATUS;
        op_nxt    = OP_NONE;
        unique case (op_r)
          OP_LOCK:      clr_mask = block_mask_t'(1) << tgt_r;
          OP_ERASE:     set_mask = block_mask_t'(1) << tgt_r;
          OP_ERASE_ALL: set_mask = protection_override ? '1 : lock_bits;
          default:      set_mask = '0;
        endcase
      end
    end else if (wr_en) begin
      if (state_r == ST_PAGE_DATA) begin
        // data write: start only on an open block or with override high, and no error pending
        if (err_any || !wr_allowed) begin
          err_prog_nxt = 1'b1;
          state_nxt    = ST_STATUS;
          op_nxt       = OP_NONE;
        end else begin
          state_nxt = ST_BUSY;
          op_nxt    = OP_PROG;
          tgt_nxt   = wr_blk;
          timer_nxt = `TIMER_W'(PAGE_PROG_CYCLES);
        end
      end else if (state_r == ST_CONFIRM && wr_data == `CMD_VERIFY) begin
        tgt_nxt = wr_blk;
        if (op_r == OP_ERASE_ALL) begin
          if (err_any) begin
            err_erase_nxt = 1'b1;
            state_nxt     = ST_STATUS;
          end else begin
            state_nxt = ST_BUSY;
            timer_nxt = `TIMER_W'(BLOCK_ERASE_CYCLES);
          end
        end else if (!wr_end || err_any) begin
          err_prog_nxt  = err_prog_r | (op_r == OP_LOCK);
          err_erase_nxt = err_erase_r | (op_r == OP_ERASE);
          state_nxt     = ST_STATUS;
        end else if (op_r == OP_ERASE && !wr_allowed) begin
          err_erase_nxt = 1'b1;
          state_nxt     = ST_STATUS;
        end else begin
          state_nxt = ST_BUSY;
          timer_nxt = (op_r == OP_LOCK) ? `TIMER_W'(PAGE_PROG_CYCLES) : `TIMER_W'(BLOCK_ERASE_CYCLES);
        end
        if (state_nxt == ST_STATUS) begin
          op_nxt = OP_NONE;
        end
      end else if (state_r == ST_CONFIRM && wr_data == `CMD_READ_ARRAY) begin
        // cancel without error
        state_nxt = ST_ARRAY;
        op_nxt    = OP_NONE;
      end else if (state_r == ST_CONFIRM) begin
        // any other word ends the pending command in error
        err_prog_nxt  = err_prog_r | (op_r == OP_LOCK);
        err_erase_nxt = err_erase_r | (op_r != OP_LOCK);
        state_nxt     = ST_STATUS;
        op_nxt        = OP_NONE;
      end else begin
        // plain command decode; unknown words are ignored
        unique case (wr_data)
          `CMD_READ_ARRAY:     state_nxt = ST_ARRAY;
          `CMD_READ_STATUS:    state_nxt = ST_STATUS;
          `CMD_READ_LOCK:      state_nxt = ST_LOCK_READ;
          `CMD_PAGE_PROG:      state_nxt = ST_PAGE_DATA;
          `CMD_CLEAR_STATUS: begin
            err_prog_nxt  = 1'b0;
            err_erase_nxt = 1'b0;
          end
          `CMD_LOCK_PROG: begin
            state_nxt = ST_CONFIRM;
            op_nxt    = OP_LOCK;
          end
          `CMD_BLOCK_ERASE: begin
            state_nxt = ST_CONFIRM;
            op_nxt    = OP_ERASE;
          end
          `CMD_ERASE_UNLOCKED: begin
            state_nxt = ST_CONFIRM;
            op_nxt    = OP_ERASE_ALL;
          end
          default:             state_nxt = state_r;
        endcase
      end
    end
    flash_ready_nxt = (state_nxt != ST_BUSY);
  end

  // ==========================================================
  // read path; the lock word register only changes on a lock read
  always_comb begin
    rd_valid_nxt          = rd_en;
    rd_data_nxt           = rd_data_r;
    block_lock_status_nxt = block_lock_status_r;
    if (rd_en) begin
      unique case (state_r)
        ST_ARRAY:     rd_data_nxt = array_rdata;
        ST_LOCK_READ: begin
          if (rd_end) begin
            block_lock_status_nxt = lock_word(lock_bits[rd_blk]);
            rd_data_nxt           = block_lock_status_nxt;
          end else begin
            rd_data_nxt = '0;
          end
        end
        default:      rd_data_nxt = status_word;
      endcase
    end
  end

  // control registers
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_r       <= ST_ARRAY;
      op_r          <= OP_NONE;
      tgt_r         <= '0;
      timer_r       <= '0;
      err_prog_r    <= 1'b0;
      err_erase_r   <= 1'b0;
      rd_data_r     <= '0;
      rd_valid_r    <= 1'b0;
      flash_ready_r <= 1'b1;
    end else begin
      state_r       <= state_nxt;
      op_r          <= op_nxt;
      tgt_r         <= tgt_nxt;
      timer_r       <= timer_nxt;
      err_prog_r    <= err_prog_nxt;
      err_erase_r   <= err_erase_nxt;
      rd_data_r     <= rd_data_nxt;
      rd_valid_r    <= rd_valid_nxt;
      flash_ready_r <= flash_ready_nxt;
    end
  end
  // left unreset on purpose: its content is undefined until a lock read
  always_ff @(posedge clk_sys) begin
    block_lock_status_r <= block_lock_status_nxt;
  end

  // ==========================================================
  // checks
  sequence s_lock_confirm;
    wr_en && state_r == ST_CONFIRM && op_r == OP_LOCK && wr_data == `CMD_VERIFY && wr_end && !err_any;
  endsequence
  sequence s_lock_done;
    done && op_r == OP_LOCK;
  endsequence
  lock_start_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_lock_confirm |=> state_r == ST_BUSY && op_r == OP_LOCK && !flash_ready_r)
    else $error("lock confirm did not start the operation");
  lock_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_lock_done |=> !lock_bits[$past(tgt_r)] && flash_ready_r)
    else $error("lock program left the bit set");
  erase_unlock_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (done && op_r == OP_ERASE) |=> lock_bits[$past(tgt_r)])
    else $error("block erase did not release the lock bit");
  only_erase_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !(done && (op_r == OP_ERASE || op_r == OP_ERASE_ALL)) |=> (lock_bits & ~$past(lock_bits)) == '0)
    else $error("lock bit set without an erase");
  refuse_prog_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (wr_en && state_r == ST_PAGE_DATA && !lock_bits[wr_blk] && !protection_override)
      |=> state_r == ST_STATUS && err_prog_r ##1 flash_ready_r)
    else $error("program on a locked block was not refused");
  mirror_bits_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (rd_en && state_r == ST_LOCK_READ && rd_end)
      |=> rd_valid_r && rd_data_r[`LOCK_PRIMARY_BIT] == rd_data_r[`LOCK_MIRROR_BIT]
          && rd_data_r[`LOCK_PRIMARY_BIT] == $past(lock_bits[rd_blk]))
    else $error("lock word does not show the addressed lock bit twice");
  status_ro_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !(rd_en && state_r == ST_LOCK_READ && rd_end) |=> $stable(block_lock_status_r))
    else $error("lock status word changed outside a lock read");
  busy_ready_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(state_r == ST_BUSY) |-> !flash_ready_r && (!rd_en || !rd_data_nxt[`STAT_READY_BIT]))
    else $error("ready shown while the array is busy");
endmodule

// >>> src/lock_bit_store.sv
// nonvolatile per-block lock bit array
`timescale 1ns/100ps
module lock_bit_store import flash_lock_pkg::*; (
  // clock and reset (reset is seen only by the checks)
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // update strobes
  input  wire block_mask_t set_mask,
  input  wire block_mask_t clr_mask,
  // stored bits
  output block_mask_t      lock_bits
);

  // ==========================================================
  // storage
  block_mask_t bits_r = '1;  // a fresh part starts erased, every block open
  block_mask_t bits_nxt;

  // set only comes from an erase; no reset so the bits survive it
  always_comb begin
    bits_nxt = (bits_r & ~clr_mask) | set_mask;
  end

  always_ff @(posedge clk_sys) begin
    bits_r <= bits_nxt;
  end

  assign lock_bits = bits_r;

  // ==========================================================
  // checks
  nv_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (set_mask == '0 && clr_mask == '0) |=> $stable(bits_r))
    else $error("lock bits changed without an update");
endmodule

// >>> test/cpu_bus_model.sv
// far side model: the words the flash array returns and the block end map
`timescale 1ns/100ps
`include "flash_lock_map.svh"
module cpu_bus_model import flash_lock_pkg::*; (
  // read address seen by the array
  input  wire logic [`ADDR_W-1:0] rd_addr,
  // word the array returns
  output logic      [`DATA_W-1:0] array_rdata
);
  // ==========================================================
  // array contents
  // array word depends on address so a stuck read path shows up
  assign array_rdata = rd_addr[15:0] ^ 16'h3c5a;

  // ==========================================================
  // block end addresses, the only place a lock or block erase confirm or a lock read may aim
  function automatic logic [`ADDR_W-1:0] blk_end(input int i);
    case (i)
      0: blk_end = `BLOCK_END_0;
      1: blk_end = `BLOCK_END_1;
      2: blk_end = `BLOCK_END_2;
      3: blk_end = `BLOCK_END_3;
      4: blk_end = `BLOCK_END_4;
      5: blk_end = `BLOCK_END_5;
      6: blk_end = `BLOCK_END_6;
      7: blk_end = `BLOCK_END_7;
      8: blk_end = `BLOCK_END_8;
      9: blk_end = `BLOCK_END_9;
      default: blk_end = `BLOCK_END_10;
    endcase
  endfunction
endmodule

// >>> test/test_flash_lock_seq.sv
// self-checking bench for the flash block lock sequencer
`timescale 1ns/100ps
`include "flash_lock_map.svh"
module test_flash_lock_seq import flash_lock_pkg::*; ;
  localparam int          PROG_N  = 8;
  localparam int          ERASE_N = 20;
  localparam logic [15:0] FREE    = 16'h0202;  // both lock copies 1, spare bits 0
  logic               clk_sys = 1'b0;
  logic               rst_n   = 1'b0;
  logic               wr_en = 1'b0;
  logic               rd_en = 1'b0;
  logic               protection_override = 1'b0;
  logic               rd_valid_r, flash_ready_r, vld;
  logic [`ADDR_W-1:0] wr_addr = 20'h00000;
  logic [`ADDR_W-1:0] rd_addr = 20'h00000;
  logic [`DATA_W-1:0] wr_data = 16'h0000;
  logic [`DATA_W-1:0] array_rdata, rd_data_r, rdat;
  int                 error_cnt = 0;
  int                 check_count = 0;
  int                 n;

  always #20 clk_sys = ~clk_sys;

  // ==========================================================
  // design and cpu model; short busy counts keep the run brief
  flash_lock_seq #(.PAGE_PROG_CYCLES(PROG_N), .BLOCK_ERASE_CYCLES(ERASE_N)) dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
    .rd_en(rd_en), .rd_addr(rd_addr), .rd_data_r(rd_data_r), .rd_valid_r(rd_valid_r),
    .array_rdata(array_rdata), .protection_override(protection_override),
    .flash_ready_r(flash_ready_r));
  cpu_bus_model model (.rd_addr(rd_addr), .array_rdata(array_rdata));

  // ==========================================================
  // helpers
  // one write strobe; the released bus carries the inverse word
  task automatic write_word(input logic [`ADDR_W-1:0] a, input logic [`DATA_W-1:0] d);
    @(posedge clk_sys);
    wr_en   <= 1'b1;
    wr_addr <= a;
    wr_data <= d;
    @(posedge clk_sys);
    wr_en   <= 1'b0;
    wr_data <= ~d;
  endtask

  // the answer is registered, so it is taken just after the edge that launches it
  task automatic read_word(input logic [`ADDR_W-1:0] a, output logic [`DATA_W-1:0] d, output logic v);
    @(posedge clk_sys);
    rd_en   <= 1'b1;
    rd_addr <= a;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    #1;
    v = rd_valid_r;
    d = rd_data_r;
  endtask

  task automatic set_override(input logic v);
    @(posedge clk_sys) protection_override <= v;
  endtask

  // protect: command word then confirm at the block end
  task automatic lock_block(input int i);
    write_word(20'h00000, `CMD_LOCK_PROG);
    write_word(model.blk_end(i), `CMD_VERIFY);
  endtask

  task automatic erase_block(input int i);
    write_word(20'h00000, `CMD_BLOCK_ERASE);
    write_word(model.blk_end(i), `CMD_VERIFY);
  endtask

  task automatic read_lock(input int i, output logic [`DATA_W-1:0] d, output logic v);
    write_word(20'h00000, `CMD_READ_LOCK);
    read_word(model.blk_end(i), d, v);
  endtask

  task automatic check_word(input string name, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic end_of_test();
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // counts ready-low cycles after a starting write; gives up if busy never starts
  task automatic busy_len(output int cnt);
    cnt = 0;
    for (int k = 0; k < 3000; k++) begin
      #1;
      if (flash_ready_r === 1'b0) cnt++;
      else if (cnt > 0 || k > 2) break;
      @(posedge clk_sys);
    end
  endtask

  task automatic lock_is(input int i, input logic [15:0] exp);
    read_lock(i, rdat, vld);
    check_word("read valid", 16'h0001, {15'h0000, vld});
    check_word("lock word", exp, rdat);
  endtask

  task automatic status_is(input logic [15:0] exp);
    write_word(20'h00000, `CMD_READ_STATUS);
    read_word(20'h00100, rdat, vld);
    check_word("status word", exp, rdat);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    // start from a known erased state whatever the array held before
    set_override(1'b1);
    write_word(20'h00000, `CMD_ERASE_UNLOCKED);
    write_word(20'h00000, `CMD_VERIFY);
    busy_len(n);
    check_word("erase-all busy", 16'(ERASE_N), n[15:0]);
    set_override(1'b0);
    for (int i = 0; i < `NUM_BLOCKS; i++) lock_is(i, FREE);
    // a page program on an open block runs for the program time
    write_word(20'h00000, `CMD_PAGE_PROG);
    write_word(20'h3f000, 16'h1234);
    busy_len(n);
    check_word("program busy", 16'(PROG_N), n[15:0]);
    status_is(16'h0080);
    // a confirm off the block end fails and protects nothing
    write_word(20'h00000, `CMD_LOCK_PROG);
    write_word(20'h0f000, `CMD_VERIFY);
    status_is(16'h0090);
    write_word(20'h00000, `CMD_CLEAR_STATUS);
    lock_is(3, FREE);
    // protect block 3 only
    lock_block(3);
    busy_len(n);
    check_word("lock busy", 16'(PROG_N), n[15:0]);
    lock_is(3, 16'h0000);
    lock_is(2, FREE);
    lock_is(4, FREE);
    // erase and program of the protected block end in errors, never busy
    erase_block(3);
    busy_len(n);
    check_word("refused erase busy", 16'h0000, n[15:0]);
    status_is(16'h00a0);
    write_word(20'h00000, `CMD_CLEAR_STATUS);
    write_word(20'h00000, `CMD_PAGE_PROG);
    write_word(20'h0f000, 16'h1234);
    status_is(16'h0090);
    write_word(20'h00000, `CMD_CLEAR_STATUS);
    status_is(16'h0080);
    // writing the lock word or cancelling a lock leaves the bits alone
    write_word(20'h00000, `CMD_READ_LOCK);
    write_word(model.blk_end(3), FREE);
    lock_is(3, 16'h0000);
    write_word(20'h00000, `CMD_LOCK_PROG);
    write_word(20'h00000, `CMD_READ_ARRAY);
    read_word(20'h00040, rdat, vld);
    check_word("array word", 16'h3c1a, rdat);
    lock_is(6, FREE);
    // reset in mid-run from lock read mode: lock bits persist, mode returns to array
    @(posedge clk_sys) rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    #1;
    check_word("ready after reset", 16'h0001, {15'h0000, flash_ready_r});
    read_word(20'h00040, rdat, vld);
    check_word("array after reset", 16'h3c1a, rdat);
    lock_is(3, 16'h0000);
    lock_is(6, FREE);
    // override then erase is the only way back to unprotected
    set_override(1'b1);
    erase_block(3);
    busy_len(n);
    check_word("erase busy", 16'(ERASE_N), n[15:0]);
    lock_is(3, FREE);
    // override dropped again: protection is honoured once more
    set_override(1'b0);
    lock_block(5);
    busy_len(n);
    set_override(1'b1);
    set_override(1'b0);
    erase_block(5);
    busy_len(n);
    check_word("erase after override off", 16'h0000, n[15:0]);
    status_is(16'h00a0);
    write_word(20'h00000, `CMD_CLEAR_STATUS);
    write_word(20'h00000, `CMD_ERASE_UNLOCKED);
    write_word(20'h00000, `CMD_VERIFY);
    busy_len(n);
    lock_is(5, 16'h0000);
    end_of_test();
  end

  // whole sequence needs a few hundred cycles; stop well past that
  initial begin
    #400000;
    error_cnt++;
    end_of_test();
  end
endmodule
